// File: rtl/rtrc_defines.vh
// Purpose: constants for the rotary touch register control block
// Assumes: 8-bit registers, pointer indexes 0x00..0x0b
// Notes: definitions only
`ifndef RTRC_DEFINES_VH
`define RTRC_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define RTRC_A_QUEUE 4'h0
`define RTRC_A_FAULT 4'h1
`define RTRC_A_STATUS 4'h2
`define RTRC_A_ROTCFG 4'h3
`define RTRC_A_THRESH 4'h4
`define RTRC_A_TICK 4'h5
`define RTRC_A_SCAN 4'h6
`define RTRC_A_CLICK 4'h7
`define RTRC_A_POWER 4'h8
`define RTRC_A_HELD 4'h9
`define RTRC_A_MODE 4'ha
`define RTRC_A_INFO 4'hb

// ****************************************
// reset values
// ****************************************
`define RTRC_R_QUEUE 8'h40
`define RTRC_R_ROTCFG 8'h81
`define RTRC_R_TICK 8'h05
`define RTRC_R_SCAN 8'h01
`define RTRC_R_CLICK 8'h01
`define RTRC_R_MODE 8'h14

// ****************************************
// field positions
// ****************************************
`define RTRC_B_CLICK 7
`define RTRC_B_CAL 4
`define RTRC_B_LOGREL 3
`define RTRC_B_LOGTCH 2
`define RTRC_B_SENSE 0
`define RTRC_ROTCFG_MASK 8'h9d
`define RTRC_B_RUN 1
`define RTRC_B_DUTY 2
`define RTRC_B_RSTN 0
`define RTRC_SCAN_MAX 8'h1f
`define RTRC_TOUCHED_BIT 8'h80

// ****************************************
// timing
// ****************************************
`define RTRC_CLK_MHZ 40
`define RTRC_GLITCH_NS 100
`define RTRC_GLITCH_CYC ((`RTRC_GLITCH_NS * `RTRC_CLK_MHZ) / 1000)

`endif

// File: rtl/rtrc_register_control.v
// Purpose: i2c slave register file and touch interpretation of a rotary touch controller
// Assumes: scl/sda from pins, pad detections from an analog front end on sys_clk
// Notes: sda is open drain, shown as in/out/enable
`timescale 1ns/1ps
`include "rtrc_defines.vh"

// Function
// - active-low software reset aborts transfer, restores registers, waits for start.
// - burst pointer: 1,3..9 increment; 2 and 0x0a wrap; 0 and 0x0b hold.
// - status reports untouched or one of eight pad positions.
// - a touch between two pads reports untouched.
// - several pads over threshold at once report untouched.
// - a significantly stronger pad among simultaneous touches is reported.
// - a later pad touched while first is held is ignored.
// - first released while later held: report release then touch of later.
// - config bit 7 gates click feedback to the sounder.
// - config bit 4 enables auto calibration.
// - config bit 3 logs release events into the queue.
// - config bit 2 logs touch events into the queue.
// - config bit 0 enables touch sensing.
// - scan factor equals stored value plus one.
// - written scan values above 0x1f are forced to 0x1f.
// - first write byte sets the pointer; later bytes written from it.
// - reads start from the stored pointer.
// - in run mode only the mode register accepts writes.
module rtrc_register_control (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // i2c pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire addr_sel,
  // front end
  input wire [7:0] pad_over,
  input wire [7:0] pad_between,
  input wire [2:0] strong_pad,
  input wire strong_valid,
  // feature outputs
  output reg click_feedback_en,
  output reg auto_calib_en,
  output reg log_release_en,
  output reg log_touch_en,
  output reg sensing_en,
  output reg [5:0] scan_period_factor,
  output reg run_mode,
  output reg stop_bus_active_mode,
  output reg event_valid,
  output reg [7:0] event_data,
  output reg click_pulse,
  output reg [7:0] tick_period,
  output reg [7:0] threshold
);

  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_AACK = 3'd2;
  localparam S_WBYTE = 3'd3;
  localparam S_WACK = 3'd4;
  localparam S_RBYTE = 3'd5;
  localparam S_RACK = 3'd6;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  always @(posedge sys_clk) begin
    scl_m_q <= scl_in;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_in;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
  end
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] rotcfg_q, thresh_q, tick_q, scan_q, click_q, power_q, held_q, mode_q;
  reg [7:0] queue_q, status_q;
  reg [3:0] ptr_q;
  reg [2:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg rw_q, first_q, sda_drv_q;
  reg soft_rst_q;

  function [3:0] next_ptr;
    input [3:0] p;
    begin
      case (p)
        4'h2, 4'ha: next_ptr = 4'h0;
        4'h0, 4'hb: next_ptr = p;
        default: next_ptr = (p > 4'hb) ? p : p + 4'h1;
      endcase
    end
  endfunction

  reg [7:0] rd_mux;
  always @* begin
    case (ptr_q)
      `RTRC_A_QUEUE: rd_mux = queue_q;
      `RTRC_A_FAULT: rd_mux = 8'h00;
      `RTRC_A_STATUS: rd_mux = status_q;
      `RTRC_A_ROTCFG: rd_mux = rotcfg_q & `RTRC_ROTCFG_MASK;
      `RTRC_A_THRESH: rd_mux = thresh_q;
      `RTRC_A_TICK: rd_mux = tick_q;
      `RTRC_A_SCAN: rd_mux = scan_q;
      `RTRC_A_CLICK: rd_mux = click_q;
      `RTRC_A_POWER: rd_mux = power_q;
      `RTRC_A_HELD: rd_mux = held_q;
      `RTRC_A_MODE: rd_mux = mode_q;
      `RTRC_A_INFO: rd_mux = 8'hff;
      default: rd_mux = 8'h00;
    endcase
  end

  wire [6:0] my_addr = {6'h26, addr_sel};
  wire in_run = mode_q[`RTRC_B_RUN];
  wire rst_all = reset | soft_rst_q;

  // ****************************************
  // i2c slave
  // ****************************************
  reg wr_stb;
  reg [7:0] wr_byte;
  always @(posedge sys_clk) begin
    wr_stb <= 1'b0;
    if (rst_all) begin
      st_q <= S_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      sda_drv_q <= 1'b0;
      ptr_q <= 4'h0;
      wr_byte <= 8'h00;
    end else if (start_c) begin
      // any start, repeated or not, reselects the slave
      st_q <= S_ADDR;
      bit_q <= 4'h0;
      sda_drv_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= S_IDLE;
      sda_drv_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: st_q <= S_IDLE;
        S_ADDR, S_WBYTE: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (st_q == S_ADDR) begin
              if (sh_q[7:1] == my_addr) begin
                rw_q <= sh_q[0];
                first_q <= 1'b1;
                sda_drv_q <= 1'b1;
                st_q <= S_AACK;
              end else begin
                st_q <= S_IDLE;
              end
            end else begin
              sda_drv_q <= 1'b1;
              st_q <= S_WACK;
              if (first_q) begin
                ptr_q <= sh_q[3:0];
                first_q <= 1'b0;
              end else begin
                wr_stb <= 1'b1;
                wr_byte <= sh_q;
                ptr_q <= next_ptr(ptr_q);
              end
            end
          end
        end
        S_AACK, S_WACK: begin
          if (scl_fall) begin
            if (st_q == S_AACK && rw_q) begin
              sh_q <= rd_mux;
              sda_drv_q <= ~rd_mux[7];
              bit_q <= 4'h1;
              st_q <= S_RBYTE;
            end else begin
              sda_drv_q <= 1'b0;
              st_q <= S_WBYTE;
            end
          end
        end
        S_RBYTE: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_drv_q <= 1'b0;
              ptr_q <= next_ptr(ptr_q);
              st_q <= S_RACK;
            end else begin
              sda_drv_q <= ~sh_q[7 - bit_q[2:0]];
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            st_q <= sda_s_q ? S_IDLE : S_RACK;
          end else if (scl_fall) begin
            sh_q <= rd_mux;
            sda_drv_q <= ~rd_mux[7];
            bit_q <= 4'h1;
            st_q <= S_RBYTE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = sda_drv_q;

  // ****************************************
  // register writes
  // ****************************************
  reg [3:0] wr_ptr_q;
  always @(posedge sys_clk) begin
    if (rst_all) wr_ptr_q <= 4'h0;
    else if (st_q == S_WBYTE && scl_fall && bit_q == 4'h8) wr_ptr_q <= ptr_q;
  end

  always @(posedge sys_clk) begin
    if (rst_all) begin
      rotcfg_q <= `RTRC_R_ROTCFG;
      thresh_q <= 8'h00;
      tick_q <= `RTRC_R_TICK;
      scan_q <= `RTRC_R_SCAN;
      click_q <= `RTRC_R_CLICK;
      power_q <= 8'h00;
      held_q <= 8'h00;
      mode_q <= `RTRC_R_MODE;
      soft_rst_q <= 1'b0;
    end else if (wr_stb) begin
      if (wr_ptr_q == `RTRC_A_MODE) begin
        mode_q <= wr_byte;
        soft_rst_q <= ~wr_byte[`RTRC_B_RSTN];
      end else if (!in_run) begin
        case (wr_ptr_q)
          `RTRC_A_ROTCFG: rotcfg_q <= wr_byte & `RTRC_ROTCFG_MASK;
          `RTRC_A_THRESH: thresh_q <= wr_byte;
          `RTRC_A_TICK: tick_q <= wr_byte;
          `RTRC_A_SCAN: scan_q <= (wr_byte > `RTRC_SCAN_MAX) ? `RTRC_SCAN_MAX : wr_byte;
          `RTRC_A_CLICK: click_q <= wr_byte;
          `RTRC_A_POWER: power_q <= wr_byte;
          `RTRC_A_HELD: held_q <= wr_byte;
          default: thresh_q <= thresh_q;
        endcase
      end
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      click_feedback_en <= 1'b1;
      auto_calib_en <= 1'b0;
      log_release_en <= 1'b0;
      log_touch_en <= 1'b0;
      sensing_en <= 1'b1;
      scan_period_factor <= 6'h02;
      run_mode <= 1'b0;
      stop_bus_active_mode <= 1'b1;
      tick_period <= `RTRC_R_TICK;
      threshold <= 8'h00;
    end else begin
      click_feedback_en <= rotcfg_q[`RTRC_B_CLICK];
      auto_calib_en <= rotcfg_q[`RTRC_B_CAL];
      log_release_en <= rotcfg_q[`RTRC_B_LOGREL];
      log_touch_en <= rotcfg_q[`RTRC_B_LOGTCH];
      sensing_en <= rotcfg_q[`RTRC_B_SENSE];
      scan_period_factor <= {1'b0, scan_q[4:0]} + 6'h01;
      run_mode <= in_run;
      stop_bus_active_mode <= ~in_run & mode_q[`RTRC_B_DUTY];
      tick_period <= tick_q;
      threshold <= thresh_q;
    end
  end

  // ****************************************
  // touch interpretation
  // ****************************************
  // pads between positions count as no touch at all
  wire [7:0] clean = pad_over & ~pad_between;
  reg [3:0] cnt;
  reg [2:0] one_idx;
  integer i;
  always @* begin
    cnt = 4'h0;
    one_idx = 3'd0;
    for (i = 0; i < 8; i = i + 1) begin
      if (clean[i]) begin
        cnt = cnt + 4'h1;
        one_idx = i[2:0];
      end
    end
  end

  reg held_v_q, roll_q;
  reg [2:0] held_p_q;
  reg [7:0] prev_q;
  wire sense_on = rotcfg_q[`RTRC_B_SENSE];
  wire [7:0] live = sense_on ? clean : 8'h00;
  wire [7:0] newly = live & ~prev_q;
  wire held_still = live[held_p_q];

  always @(posedge sys_clk) begin
    event_valid <= 1'b0;
    click_pulse <= 1'b0;
    if (rst_all) begin
      held_v_q <= 1'b0;
      roll_q <= 1'b0;
      held_p_q <= 3'd0;
      prev_q <= 8'h00;
      status_q <= 8'h00;
      queue_q <= `RTRC_R_QUEUE;
      event_data <= 8'h00;
    end else begin
      prev_q <= live;
      roll_q <= 1'b0;
      // handover touch goes one cycle after the release event
      if (roll_q && rotcfg_q[`RTRC_B_LOGTCH]) begin
        event_valid <= 1'b1;
        event_data <= `RTRC_TOUCHED_BIT | {5'h00, held_p_q};
        queue_q <= `RTRC_TOUCHED_BIT | {5'h00, held_p_q};
        click_pulse <= rotcfg_q[`RTRC_B_CLICK];
      end
      if (held_v_q) begin
        if (!held_still) begin
          // held pad released: ownership passes to another still-held pad if one remains, else the touch ends
          if (rotcfg_q[`RTRC_B_LOGREL]) begin
            event_valid <= 1'b1;
            event_data <= {5'h00, held_p_q};
            queue_q <= {5'h00, held_p_q};
          end
          if (cnt != 4'h0 && (prev_q & live) != 8'h00) begin
            held_p_q <= one_idx;
            roll_q <= 1'b1;
            status_q <= `RTRC_TOUCHED_BIT | {5'h00, one_idx};
          end else begin
            held_v_q <= 1'b0;
            status_q <= 8'h00;
          end
        end
        // second pad while held is simply ignored
      end else if (newly != 8'h00) begin
        if (cnt == 4'h1 || (cnt > 4'h1 && strong_valid && live[strong_pad])) begin
          held_v_q <= 1'b1;
          held_p_q <= (cnt == 4'h1) ? one_idx : strong_pad;
          status_q <= `RTRC_TOUCHED_BIT | {5'h00, (cnt == 4'h1) ? one_idx : strong_pad};
          click_pulse <= rotcfg_q[`RTRC_B_CLICK];
          if (rotcfg_q[`RTRC_B_LOGTCH]) begin
            event_valid <= 1'b1;
            event_data <= `RTRC_TOUCHED_BIT | {5'h00, (cnt == 4'h1) ? one_idx : strong_pad};
            queue_q <= `RTRC_TOUCHED_BIT | {5'h00, (cnt == 4'h1) ? one_idx : strong_pad};
          end
        end
      end
    end
  end

endmodule

// File: dv/rtrc_monitor.sv
// Purpose: port checker for rtrc_register_control
// Assumes: events and clicks are one-cycle pulses
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module rtrc_monitor (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // front end
  input wire [7:0] pad_over,
  input wire [7:0] pad_between,
  // features and events
  input wire click_feedback_en,
  input wire auto_calib_en,
  input wire log_release_en,
  input wire log_touch_en,
  input wire sensing_en,
  input wire [5:0] scan_period_factor,
  input wire event_valid,
  input wire [7:0] event_data,
  input wire click_pulse,
  input wire [7:0] tick_period,
  input wire [7:0] threshold
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire tch = event_valid && event_data[7];
  a_reset_values: assert property (
    $past(reset) |-> click_feedback_en && sensing_en && !auto_calib_en && !log_touch_en
    && tick_period == 8'h05 && threshold == 8'h00 && scan_period_factor == 6'd2)
    else $error("feature outputs wrong after reset");
  a_click_cause: assert property (click_pulse |-> click_feedback_en && tch)
    else $error("click without accepted touch");
  a_touch_log: assert property (tch |-> log_touch_en && sensing_en)
    else $error("touch event while disabled");
  a_release_log: assert property (event_valid && !event_data[7] |-> log_release_en)
    else $error("release event while disabled");
  a_scan_range: assert property (scan_period_factor >= 6'd1 && scan_period_factor <= 6'd32)
    else $error("scan factor out of range");
  a_pad_cause: assert property (
    tch |-> (($past(pad_over) >> event_data[2:0]) & 8'h01) != 8'h00)
    else $error("touch reported on idle pad");
  a_no_between: assert property (tch |-> $past(pad_between) == 8'h00)
    else $error("touch reported between pads");
  a_event_fields: assert property (event_valid |-> event_data[6:3] == 4'h0)
    else $error("event carries stray bits");
  c_touch: cover property (tch);
  c_release: cover property (event_valid && !event_data[7]);
  c_click: cover property (click_pulse);
endmodule
bind rtrc_register_control rtrc_monitor mon (.sys_clk, .reset, .pad_over, .pad_between,
  .click_feedback_en, .auto_calib_en, .log_release_en, .log_touch_en, .sensing_en,
  .scan_period_factor, .event_valid, .event_data, .click_pulse, .tick_period, .threshold);

// File: dv/rtrc_host.sv
// Purpose: i2c master model on the far side of the block
// Assumes: sda has a pull-up, scl idles high between frames
// Notes: bit time 200 ns; ack holds the sampled ninth bit
`timescale 1ns/1ps
module rtrc_host (
  // link
  output reg scl,
  output reg sda_h,
  input wire sda
);
  reg ack;
  reg [7:0] rx;
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
    ack = 1'b1;
  end
  // sda moves 10 ns after scl fell, 110 ns before scl rises
  task bitx(input b);
    begin
      #10 sda_h = b;
      #110 scl = 1'b1;
      #80 ack = sda;
      scl = 1'b0;
    end
  endtask
  // sole master: bus owned from start to stop
  task start;
    begin
      #10 sda_h = 1'b1;
      #110 scl = 1'b1;
      #100 sda_h = 1'b0;
      #100 scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #10 sda_h = 1'b0;
      #110 scl = 1'b1;
      #100 sda_h = 1'b1;
      #100;
    end
  endtask
  task send(input [7:0] b);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) bitx(b[k]);
      bitx(1'b1);
    end
  endtask
  // one byte read, closed by a nack
  task recv;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        bitx(1'b1);
        rx = {rx[6:0], ack};
      end
      bitx(1'b1);
    end
  endtask
endmodule

// File: dv/test_rtrc_register_control.sv
// Purpose: self-checking bench for rtrc_register_control
// Assumes: host model on the i2c pins, front end driven here
// Notes: events are matched in order against a queue of notes
`timescale 1ns/1ps
`include "rtrc_defines.vh"
module test_rtrc_register_control;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] pad_over = 8'h00, pad_between = 8'h00, rnd = 8'h5e;
  reg [2:0] strong_pad = 3'h0, p, q;
  reg strong_valid = 1'b0;
  wire scl, sda_h, sda_out, sda_oe, click_feedback_en, auto_calib_en, log_release_en;
  wire log_touch_en, sensing_en, run_mode, stop_bus_active_mode, event_valid, click_pulse;
  wire [5:0] scan_period_factor;
  wire [7:0] event_data, tick_period, threshold;
  wire sda = (sda_oe ? sda_out : 1'b1) & sda_h;
  integer n_mismatch = 0, comparisons = 0, i;
  logic [7:0] expq[$];
  logic [7:0] sv[4] = '{8'h00, 8'h1f, 8'h20, 8'hff};
  logic [7:0] sf[4] = '{8'd1, 8'd32, 8'd32, 8'd32};
  always #12.5 sys_clk = ~sys_clk;
  rtrc_register_control uut (.sys_clk, .reset, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .addr_sel(1'b1), .pad_over, .pad_between, .strong_pad, .strong_valid, .click_feedback_en,
    .auto_calib_en, .log_release_en, .log_touch_en, .sensing_en, .scan_period_factor,
    .run_mode, .stop_bus_active_mode, .event_valid, .event_data, .click_pulse, .tick_period,
    .threshold);
  rtrc_host host (.scl, .sda_h, .sda);
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task wb(input [7:0] b, input a);
    begin
      host.send(b);
      chk(host.ack, a);
    end
  endtask
  task wreg(input [7:0] r, input [7:0] d);
    begin
      host.start;
      wb(8'h9a, 1'b0);
      wb(r, 1'b0);
      wb(d, 1'b0);
      host.stop;
    end
  endtask
  task chkrst;
    begin
      chk({click_feedback_en, auto_calib_en, log_release_en, log_touch_en, sensing_en}, 5'h11);
      chk({stop_bus_active_mode, run_mode, scan_period_factor}, {2'b10, 6'd2});
      chk({tick_period, threshold}, {`RTRC_R_TICK, 8'h00});
    end
  endtask
  // drive pads, then let pending events drain under a bound
  task pads(input [7:0] o, input [7:0] bt, input [2:0] sp, input v);
    integer j;
    begin
      @(posedge sys_clk);
      #2 pad_over = o;
      pad_between = bt;
      strong_pad = sp;
      strong_valid = v;
      for (j = 0; j < 400 && expq.size() > 0; j = j + 1) @(posedge sys_clk);
      if (expq.size() > 0) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t event missing", $time);
        test_done;
      end
      repeat (40) @(posedge sys_clk);
    end
  endtask
  always @(posedge sys_clk) begin
    if (event_valid === 1'b1) begin
      comparisons = comparisons + 1;
      if (expq.size() == 0 || event_data !== expq[0]) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t unexpected event %h", $time, event_data);
      end
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    $display("ERROR %0t run hung", $time);
    test_done;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #2 reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    chkrst;
    host.start;
    wb(8'h98, 1'b1);
    host.stop;
    host.start;
    wb(8'h9a, 1'b0);
    wb(8'h03, 1'b0);
    wb(8'h9f, 1'b0);
    wb(8'h22, 1'b0);
    wb(8'h07, 1'b0);
    wb(8'h40, 1'b0);
    host.stop;
    chk({click_feedback_en, auto_calib_en, log_release_en, log_touch_en}, 4'hf);
    chk({tick_period, threshold, 2'b00, scan_period_factor}, 24'h072220);
    host.start;
    wb(8'h9a, 1'b0);
    wb(8'h03, 1'b0);
    host.start;
    wb(8'h9b, 1'b0);
    host.recv;
    host.stop;
    chk(host.rx, 8'h9d);
    for (i = 0; i < 4; i = i + 1) begin
      wreg(8'h06, sv[i]);
      chk(scan_period_factor, sf[i]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      p = rnd[2:0];
      expq.push_back(8'h80 | p);
      pads(8'h01 << p, 8'h00, 3'h0, 1'b0);
      expq.push_back({5'h0, p});
      pads(8'h00, 8'h00, 3'h0, 1'b0);
    end
    q = p + 3'd3;
    pads((8'h01 << p) | (8'h01 << q), 8'h00, 3'h0, 1'b0);
    pads(8'h00, 8'h00, 3'h0, 1'b0);
    expq.push_back(8'h80 | q);
    pads((8'h01 << p) | (8'h01 << q), 8'h00, q, 1'b1);
    expq.push_back({5'h0, q});
    pads(8'h00, 8'h00, 3'h0, 1'b0);
    pads(8'h01 << p, 8'h01 << p, 3'h0, 1'b0);
    pads(8'h00, 8'h00, 3'h0, 1'b0);
    expq.push_back(8'h80 | p);
    pads(8'h01 << p, 8'h00, 3'h0, 1'b0);
    pads((8'h01 << p) | (8'h01 << q), 8'h00, 3'h0, 1'b0);
    expq.push_back({5'h0, p});
    expq.push_back(8'h80 | q);
    pads(8'h01 << q, 8'h00, 3'h0, 1'b0);
    expq.push_back({5'h0, q});
    pads(8'h00, 8'h00, 3'h0, 1'b0);
    wreg(8'h03, 8'h9e);
    chk(sensing_en, 1'b0);
    pads(8'h01 << p, 8'h00, 3'h0, 1'b0);
    pads(8'h00, 8'h00, 3'h0, 1'b0);
    host.start;
    wb(8'h9a, 1'b0);
    wb(8'h0a, 1'b0);
    wb(8'h14, 1'b1);
    host.stop;
    repeat (3) @(posedge sys_clk);
    chkrst;
    wreg(8'h04, 8'h55);
    chk(threshold, 8'h55);
    wreg(8'h0a, 8'h17);
    chk(run_mode, 1'b1);
    wreg(8'h04, 8'h33);
    chk(threshold, 8'h55);
    chk(expq.size(), 0);
    test_done;
  end
endmodule
